// ---- src/timebase_pkg.sv ----
package timebase_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_SLAVE = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_EVGEN = 8'h14;
  localparam logic [7:0] OFF_COUNTER = 8'h24;
  localparam logic [7:0] OFF_PRESCALE = 8'h28;
  localparam logic [7:0] OFF_RELOAD = 8'h2C;
  localparam logic [7:0] OFF_REPEAT = 8'h30;
  localparam logic [7:0] OFF_DMA_CTRL = 8'h48;
  localparam logic [7:0] OFF_WINDOW = 8'h4C;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL1_EN = 0;
  localparam int CTRL1_UPD_DIS = 1;
  localparam int CTRL1_DIR = 4;
  localparam int CTRL1_CTR_LSB = 5;
  localparam int SLV_MODE_LSB = 0;
  localparam int SLV_TSEL_LSB = 4;
  localparam int SLV_TPOL_LSB = 8;
  localparam int SLV_XPOL = 12;
  localparam int SLV_XDIV_LSB = 13;
  localparam int IE_UPD = 0;
  localparam int IE_CC = 1;
  localparam int IE_TRG = 6;
  localparam int IE_BRK = 7;
  localparam int DE_UPD = 8;
  localparam int DE_CC = 9;
  localparam int DE_TRG = 14;
  localparam int ST_UPD = 0;
  localparam int ST_CC = 1;
  localparam int ST_TRG = 6;
  localparam int ST_BRK = 7;
  localparam int EG_UPD = 0;
  localparam int EG_TRG = 6;
  localparam int DC_BASE_LSB = 0;
  localparam int DC_LEN_LSB = 8;
  // ------------------------------------------------------------
  // Slave modes and trigger sources
  // ------------------------------------------------------------
  localparam logic [2:0] SM_OFF = 3'h0;
  localparam logic [2:0] SM_EXT2 = 3'h1;
  localparam logic [2:0] SM_RESET = 3'h4;
  localparam logic [2:0] SM_GATED = 3'h5;
  localparam logic [2:0] SM_TRIGGER = 3'h6;
  localparam logic [2:0] SM_EXT1 = 3'h7;
  localparam logic [3:0] TS_TI1ED = 4'h4;
  localparam logic [3:0] TS_TI1 = 4'h5;
  localparam logic [3:0] TS_XTRIG = 4'h9;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_RELOAD = 16'hFFFF;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
endpackage

// ---- src/timebase_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
module timebase_prescaler #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic tick_in,
  input wire logic clr,
  input wire logic [W-1:0] div,
  // Counter clock enable
  output logic tick_out
);
  logic [W-1:0] pcount_q;

  // Divides by div+1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcount_q <= '0;
    end else if (clr) begin
      pcount_q <= '0;
    end else if (tick_in) begin
      pcount_q <= (pcount_q >= div) ? '0 : pcount_q + 1'b1;
    end
  end

  assign tick_out = tick_in & ~clr & (pcount_q >= div);
endmodule
`default_nettype wire

// ---- src/timebase_clock_source.sv ----
`timescale 1ns/10ps
`default_nettype none
module timebase_clock_source import timebase_pkg::*; #(
  parameter int FILT_LEN = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic [2:0] smode,
  input wire logic [3:0] tsel,
  input wire logic [3:0] ti_pol,
  input wire logic xtrig_pol,
  input wire logic [1:0] xtrig_div,
  // Sources
  input wire logic [3:0] ti,
  input wire logic ext_trig_pin,
  input wire logic [3:0] itr,
  // Results
  output logic trgi_lvl,
  output logic trgi_rise,
  output logic prescaler_input_clock
);
  logic [2:0] xdiv_q;
  logic xpol_prev_q;
  logic [4:0] raw;
  logic [4:0] filt_q;
  logic ti1_prev_q;
  logic xf_prev_q;
  logic trgi_prev_q;
  logic ti1_ed;
  logic xpol;

  // Polarity and frequency division of the trigger pin
  assign xpol = ext_trig_pin ^ xtrig_pol;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xdiv_q <= '0;
      xpol_prev_q <= 1'b0;
    end else begin
      xpol_prev_q <= xpol;
      if (xpol && !xpol_prev_q) begin
        xdiv_q <= xdiv_q + 1'b1;
      end
    end
  end

  assign raw[3:0] = ti ^ ti_pol;
  assign raw[4] = (xtrig_div == 2'd0) ? xpol : xdiv_q[xtrig_div - 2'd1]; // [RQ7]

  // Filters: output follows only after FILT_LEN equal samples
  for (genvar i = 0; i < 5; i++) begin : g_filt
    logic [FILT_LEN-1:0] sh_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sh_q <= '0;
        filt_q[i] <= 1'b0;
      end else begin
        sh_q <= {sh_q[FILT_LEN-2:0], raw[i]};
        if (&sh_q) begin
          filt_q[i] <= 1'b1; // [RQ6]
        end else if (~|sh_q) begin
          filt_q[i] <= 1'b0;
        end
      end
    end
  end

  assign ti1_ed = filt_q[0] ^ ti1_prev_q; // [RQ6]

  // Trigger selection; internal triggers bypass the filters
  always_comb begin
    if (tsel < TS_TI1ED) begin
      trgi_lvl = itr[tsel[1:0]]; // [RQ8]
    end else if (tsel == TS_TI1ED) begin
      trgi_lvl = ti1_ed;
    end else if (tsel < TS_XTRIG) begin
      trgi_lvl = filt_q[2'(tsel - TS_TI1)]; // [RQ6]
    end else begin
      trgi_lvl = filt_q[4]; // [RQ7]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ti1_prev_q <= 1'b0;
      xf_prev_q <= 1'b0;
      trgi_prev_q <= 1'b0;
    end else begin
      ti1_prev_q <= filt_q[0];
      xf_prev_q <= filt_q[4];
      trgi_prev_q <= trgi_lvl;
    end
  end

  assign trgi_rise = trgi_lvl & ~trgi_prev_q;

  always_comb begin
    case (smode)
      SM_EXT1: prescaler_input_clock = trgi_rise; // [RQ6] [RQ8]
      SM_EXT2: prescaler_input_clock = filt_q[4] & ~xf_prev_q; // [RQ7]
      default: prescaler_input_clock = 1'b1; // [RQ5]
    endcase
  end
endmodule
`default_nettype wire

// ---- src/advanced_timer_timebase.sv ----
// What this block does
// [RQ1] Window access goes to base plus index, times four
// [RQ2] Burst index advances itself on each window access
// [RQ3] Sixteen-bit counter: up, down, center-aligned
// [RQ4] Prescaler, reload 16 bits; repetition 8 bits
// [RQ5] No slave mode: internal clock feeds prescaler
// [RQ6] External mode 1: filtered channels, channel-one edges
// [RQ7] External mode 2: pin, polarity, divider, filter
// [RQ8] Internal trigger clocks counter without filtering
// [RQ9] Master resets, starts, stops or clocks slaves
// [RQ10] Direction bit picks up or down counting; center bits six to five pick center mode
// [RQ11] Up: wrap to zero at reload, overflow
// [RQ12] Down: reload at zero, overflow
// [RQ13] Center: overflow at reload-1, underflow at one
// [RQ14] Update copies preloads into active shadows
// [RQ15] Update-disable bit blocks counter-made updates
// [RQ16] Events decrement repetition; update only at zero
// [RQ17] Repetition N gives one update per N+1
// [RQ18] Interrupt outputs per event kind; DMA for all but break
// [RQ19] Repetition counter reloads when update fires
// [RQ20] Burst base offset is bits four to zero
// [RQ21] Burst length bits twelve to eight, plus one
// [RQ22] Prescaler divides by value plus one
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module advanced_timer_timebase import timebase_pkg::*; #(
  parameter int FILT_LEN = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock and trigger sources
  input wire logic [3:0] ti,
  input wire logic ext_trig_pin,
  input wire logic [3:0] itr,
  // Events from capture/compare and break logic
  input wire logic cc_event,
  input wire logic brk_event,
  // Requests and master output
  output logic irq_update,
  output logic irq_trigger,
  output logic irq_cc,
  output logic irq_break,
  output logic dma_update,
  output logic dma_trigger,
  output logic dma_cc,
  output logic trgo
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [15:0] ctrl1_q, slave_q, irq_en_q, dma_ctrl_q;
  logic [7:0] status_q;
  logic [15:0] counter_value_q, reload_pre_q, reload_act_q, presc_pre_q, presc_act_q;
  logic [7:0] rep_pre_q, rep_act_q, rep_q;
  logic [4:0] idx_q;
  logic falling_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic irq_upd_q, irq_trg_q, irq_cc_q, irq_brk_q;
  logic dma_upd_q, dma_trg_q, dma_cc_q, trgo_q;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic [4:0] burst_base_offset, burst_length;
  logic [5:0] burst_sum;
  logic [7:0] eff_addr;
  logic is_window, hit, acc, done, wr;
  logic [31:0] rd_val;

  assign burst_base_offset = dma_ctrl_q[DC_BASE_LSB +: 5]; // [RQ20]
  assign burst_length = dma_ctrl_q[DC_LEN_LSB +: 5]; // [RQ21]
  assign burst_sum = 6'(burst_base_offset) + 6'(idx_q);
  assign is_window = (paddr == OFF_WINDOW);
  assign eff_addr = is_window ? (OFF_CTRL1 + {burst_sum, 2'b00}) : paddr; // [RQ1]
  assign acc = psel & penable & ~pready_q;
  assign done = psel & penable & pready_q;
  assign wr = done & pwrite & hit;

  always_comb begin
    hit = 1'b1;
    rd_val = '0;
    case (eff_addr)
      OFF_CTRL1: rd_val = {16'h0000, ctrl1_q};
      OFF_SLAVE: rd_val = {16'h0000, slave_q};
      OFF_IRQ_EN: rd_val = {16'h0000, irq_en_q};
      OFF_STATUS: rd_val = {24'h000000, status_q};
      OFF_EVGEN: rd_val = '0;
      OFF_COUNTER: rd_val = {16'h0000, counter_value_q};
      OFF_PRESCALE: rd_val = {16'h0000, presc_pre_q};
      OFF_RELOAD: rd_val = {16'h0000, reload_pre_q};
      OFF_REPEAT: rd_val = {24'h000000, rep_pre_q};
      OFF_DMA_CTRL: rd_val = {16'h0000, dma_ctrl_q};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc & ~hit;
      if (acc && !pwrite) begin
        prdata_q <= rd_val;
      end
    end
  end

  // Burst index steps on every finished window access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= '0;
    end else if (wr && eff_addr == OFF_DMA_CTRL) begin
      idx_q <= '0;
    end else if (done && is_window) begin
      idx_q <= (idx_q >= burst_length) ? 5'd0 : idx_q + 5'd1; // [RQ2] [RQ21]
    end
  end

  // ------------------------------------------------------------
  // Clock source and prescaler
  // ------------------------------------------------------------
  logic [2:0] smode;
  logic trgi_lvl, trgi_rise, prescaler_input_clock, cnt_tick, run;
  logic sw_upd, sw_trg, slave_rst, upd, ev_ovf, ev_unf, ev;
  logic update_disable_bit, count_direction_bit;
  logic [1:0] center_sel;

  assign smode = slave_q[SLV_MODE_LSB +: 3];
  assign update_disable_bit = ctrl1_q[CTRL1_UPD_DIS];
  assign count_direction_bit = ctrl1_q[CTRL1_DIR];
  assign center_sel = ctrl1_q[CTRL1_CTR_LSB +: 2];

  timebase_clock_source #(.FILT_LEN(FILT_LEN)) u_src (
    .pclk(pclk),
    .presetn(presetn),
    .smode(smode),
    .tsel(slave_q[SLV_TSEL_LSB +: 4]),
    .ti_pol(slave_q[SLV_TPOL_LSB +: 4]),
    .xtrig_pol(slave_q[SLV_XPOL]),
    .xtrig_div(slave_q[SLV_XDIV_LSB +: 2]),
    .ti(ti),
    .ext_trig_pin(ext_trig_pin),
    .itr(itr),
    .trgi_lvl(trgi_lvl),
    .trgi_rise(trgi_rise),
    .prescaler_input_clock(prescaler_input_clock)
  );

  // Gated mode stops the count while the trigger is low
  assign run = ctrl1_q[CTRL1_EN] & ((smode != SM_GATED) | trgi_lvl); // [RQ9]
  assign slave_rst = (smode == SM_RESET) & trgi_rise; // [RQ9]
  assign sw_upd = wr & (eff_addr == OFF_EVGEN) & pwdata[EG_UPD];
  assign sw_trg = wr & (eff_addr == OFF_EVGEN) & pwdata[EG_TRG];

  timebase_prescaler #(.W(16)) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(prescaler_input_clock & run),
    .clr(sw_upd | slave_rst),
    .div(presc_act_q),
    .tick_out(cnt_tick)
  ); // [RQ22]

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  logic [15:0] cnt_nxt;
  logic fall_nxt;

  always_comb begin
    cnt_nxt = counter_value_q;
    fall_nxt = falling_q;
    ev_ovf = 1'b0;
    ev_unf = 1'b0;
    if (center_sel != 2'd0) begin
      if (reload_act_q == RST_ZERO16) begin
        cnt_nxt = RST_ZERO16;
      end else if (!falling_q) begin
        ev_ovf = (counter_value_q == reload_act_q - 16'd1); // [RQ13]
        cnt_nxt = counter_value_q + 16'd1;
        fall_nxt = (cnt_nxt >= reload_act_q);
      end else begin
        ev_unf = (counter_value_q == 16'd1); // [RQ13]
        cnt_nxt = counter_value_q - 16'd1;
        fall_nxt = (cnt_nxt != RST_ZERO16);
      end
    end else if (count_direction_bit) begin
      ev_ovf = (counter_value_q == RST_ZERO16); // [RQ12]
      cnt_nxt = ev_ovf ? reload_act_q : counter_value_q - 16'd1;
    end else begin
      ev_ovf = (counter_value_q >= reload_act_q); // [RQ11]
      cnt_nxt = ev_ovf ? RST_ZERO16 : counter_value_q + 16'd1;
    end
  end

  assign ev = cnt_tick & (ev_ovf | ev_unf);
  assign upd = (ev & (rep_q == RST_ZERO8) & ~update_disable_bit) // [RQ15] [RQ16]
             | sw_upd | slave_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value_q <= RST_ZERO16;
      falling_q <= 1'b0;
    end else if (wr && eff_addr == OFF_COUNTER) begin
      counter_value_q <= pwdata[15:0];
    end else if (sw_upd || slave_rst) begin
      counter_value_q <= count_direction_bit && center_sel == 2'd0 ? reload_act_q : RST_ZERO16;
      falling_q <= 1'b0; // [RQ9]
    end else if (cnt_tick) begin
      counter_value_q <= cnt_nxt; // [RQ3] [RQ10]
      falling_q <= fall_nxt;
    end
  end

  // Repetition counter and shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_q <= RST_ZERO8;
      rep_act_q <= RST_ZERO8;
      reload_act_q <= RST_RELOAD;
      presc_act_q <= RST_ZERO16;
    end else begin
      if (upd) begin
        rep_act_q <= rep_pre_q; // [RQ14]
        reload_act_q <= reload_pre_q;
        presc_act_q <= presc_pre_q;
        rep_q <= rep_pre_q; // [RQ19]
      end else if (ev) begin
        rep_q <= (rep_q == RST_ZERO8) ? rep_act_q : rep_q - 8'd1; // [RQ16] [RQ17]
      end
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= RST_ZERO16;
      slave_q <= RST_ZERO16;
      irq_en_q <= RST_ZERO16;
      dma_ctrl_q <= RST_ZERO16;
      reload_pre_q <= RST_RELOAD;
      presc_pre_q <= RST_ZERO16;
      rep_pre_q <= RST_ZERO8;
    end else begin
      if (wr) begin
        case (eff_addr)
          OFF_CTRL1: ctrl1_q <= pwdata[15:0] & 16'h0073;
          OFF_SLAVE: slave_q <= pwdata[15:0] & 16'h7FF7;
          OFF_IRQ_EN: irq_en_q <= pwdata[15:0] & 16'h43C3;
          OFF_DMA_CTRL: dma_ctrl_q <= pwdata[15:0] & 16'h1F1F;
          OFF_RELOAD: reload_pre_q <= pwdata[15:0]; // [RQ4]
          OFF_PRESCALE: presc_pre_q <= pwdata[15:0];
          OFF_REPEAT: rep_pre_q <= pwdata[7:0];
          default: ;
        endcase
      end
      // Trigger mode starts the counter on a trigger edge
      if (smode == SM_TRIGGER && trgi_rise) begin
        ctrl1_q[CTRL1_EN] <= 1'b1; // [RQ9]
      end
    end
  end

  // Status: write zero clears, a new event in the same cycle wins
  logic [7:0] st_set;
  always_comb begin
    st_set = '0;
    st_set[ST_UPD] = upd;
    st_set[ST_CC] = cc_event;
    st_set[ST_TRG] = trgi_rise | sw_trg;
    st_set[ST_BRK] = brk_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= RST_ZERO8;
    end else if (wr && eff_addr == OFF_STATUS) begin
      status_q <= (status_q & pwdata[7:0]) | st_set;
    end else begin
      status_q <= status_q | st_set;
    end
  end

  // Requests and master trigger output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_upd_q <= 1'b0;
      irq_trg_q <= 1'b0;
      irq_cc_q <= 1'b0;
      irq_brk_q <= 1'b0;
      dma_upd_q <= 1'b0;
      dma_trg_q <= 1'b0;
      dma_cc_q <= 1'b0;
      trgo_q <= 1'b0;
    end else begin
      irq_upd_q <= status_q[ST_UPD] & irq_en_q[IE_UPD]; // [RQ18]
      irq_trg_q <= status_q[ST_TRG] & irq_en_q[IE_TRG];
      irq_cc_q <= status_q[ST_CC] & irq_en_q[IE_CC];
      irq_brk_q <= status_q[ST_BRK] & irq_en_q[IE_BRK];
      dma_upd_q <= upd & irq_en_q[DE_UPD];
      dma_trg_q <= st_set[ST_TRG] & irq_en_q[DE_TRG];
      dma_cc_q <= cc_event & irq_en_q[DE_CC];
      trgo_q <= upd; // [RQ9]
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq_update = irq_upd_q;
  assign irq_trigger = irq_trg_q;
  assign irq_cc = irq_cc_q;
  assign irq_break = irq_brk_q;
  assign dma_update = dma_upd_q;
  assign dma_trigger = dma_trg_q;
  assign dma_cc = dma_cc_q;
  assign trgo = trgo_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic cnt_free;
  assign cnt_free = cnt_tick & ~sw_upd & ~slave_rst & ~(wr && eff_addr == OFF_COUNTER);

  property p_window_target;
    acc && is_window && !pwrite && burst_sum == 6'd9 |=> prdata == {16'h0000, $past(counter_value_q)};
  endproperty
  a_window_target: assert property (p_window_target) else $error("window read wrong target"); // [RQ1]

  property p_idx_step;
    done && is_window && idx_q < burst_length |=> idx_q == $past(idx_q) + 5'd1;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("burst index did not step"); // [RQ2]

  property p_idx_wrap;
    done && is_window && idx_q >= burst_length && !wr |=> idx_q == 5'd0;
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("burst index did not wrap"); // [RQ21]

  property p_up_wrap;
    cnt_free && center_sel == 2'd0 && !count_direction_bit && counter_value_q == reload_act_q
      |=> counter_value_q == 16'd0;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up count did not wrap"); // [RQ11]

  property p_down_reload;
    cnt_free && center_sel == 2'd0 && count_direction_bit && counter_value_q == 16'd0
      |=> counter_value_q == $past(reload_act_q);
  endproperty
  a_down_reload: assert property (p_down_reload) else $error("down count did not reload"); // [RQ12]

  property p_center_events;
    cnt_tick && center_sel != 2'd0 && reload_act_q > 16'd1 && !falling_q
      && counter_value_q == reload_act_q - 16'd1 |-> ev;
  endproperty
  a_center_events: assert property (p_center_events) else $error("center overflow missed"); // [RQ13]

  property p_shadow_load;
    upd |=> reload_act_q == $past(reload_pre_q) && presc_act_q == $past(presc_pre_q)
      && rep_q == $past(rep_pre_q);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded"); // [RQ14]

  property p_upd_disable;
    ev && update_disable_bit && !sw_upd && !slave_rst |=> !status_q[ST_UPD] || $past(status_q[ST_UPD]);
  endproperty
  a_upd_disable: assert property (p_upd_disable) else $error("update despite disable"); // [RQ15]

  property p_rep_dec;
    ev && !upd && rep_q != 8'd0 |=> rep_q == $past(rep_q) - 8'd1;
  endproperty
  a_rep_dec: assert property (p_rep_dec) else $error("repetition not decremented"); // [RQ16]

  property p_internal_clock;
    smode == SM_OFF |-> prescaler_input_clock;
  endproperty
  a_internal_clock: assert property (p_internal_clock) else $error("internal clock not used"); // [RQ5]

  property p_trgo;
    upd |=> trgo ##1 !trgo || $past(upd);
  endproperty
  a_trgo: assert property (p_trgo) else $error("master output not pulsed"); // [RQ9]

  c_update: cover property (ev && upd);
  c_window: cover property (done && is_window && idx_q == burst_length && burst_length != 5'd0);
  c_center_unf: cover property (ev_unf && cnt_tick);
  c_slave_reset: cover property (slave_rst);
endmodule
`default_nettype wire

// ---- sim/master_timer_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module master_timer_model (
  // Clock
  input wire logic pclk,
  // Trigger outputs to the slave timer
  output logic [3:0] itr
);
  initial itr = 4'h0;
  // ----------------------------------------
  // Count pulses on trigger line zero
  // ----------------------------------------
  task automatic emit(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      itr <= 4'h1;
      repeat (2) @(posedge pclk);
      itr <= 4'h0;
      @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/advanced_timer_timebase_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module advanced_timer_timebase_tb_top import timebase_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trgo;
  logic [3:0] itr;
  logic [3:0] ti_v = 4'h0;
  logic ext_pin = 1'b0;
  logic cc_ev = 1'b0;
  logic brk_ev = 1'b0;
  logic irq_update;
  logic irq_cc;
  logic irq_break;
  logic dma_update;
  logic [31:0] rd_v;
  logic er_v;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int t1;
  int t2;

  advanced_timer_timebase u_advanced_timer_timebase (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ti(ti_v), .ext_trig_pin(ext_pin),
    .itr(itr), .cc_event(cc_ev), .brk_event(brk_ev), .irq_update(irq_update),
    .irq_trigger(), .irq_cc(irq_cc), .irq_break(irq_break), .dma_update(dma_update),
    .dma_trigger(), .dma_cc(), .trgo(trgo));
  master_timer_model u_master_timer_model (.pclk(pclk), .itr(itr));

  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end

  task automatic results();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // APB master
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask
  // Pulses on the trigger pin (m[4]) or the input channels (m[3:0])
  task automatic pin_pulses(input int n, input logic [4:0] m);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      ext_pin <= m[4];
      ti_v <= m[3:0];
      repeat (6) @(posedge pclk);
      ext_pin <= 1'b0;
      ti_v <= 4'h0;
      repeat (6) @(posedge pclk);
    end
  endtask
  task automatic wait_trgo(output int t);
    t = -1;
    for (int i = 0; i < 60 && t < 0; i++) begin
      @(posedge pclk);
      if (trgo === 1'b1) t = cyc;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_regs();
    rdchk(OFF_RELOAD, 32'h0000FFFF);
    rdchk(OFF_PRESCALE, 32'h0);
    rdchk(OFF_WINDOW, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk({31'h0, er_v}, 32'h1);
  endtask
  task automatic t_requests();
    apb(1'b1, OFF_IRQ_EN, 32'h00000183);
    apb(1'b1, OFF_EVGEN, 32'h1);
    @(posedge pclk);
    chk({30'h0, dma_update, irq_update}, 32'h2);
    @(posedge pclk);
    chk({30'h0, dma_update, irq_update}, 32'h1);
    cc_ev <= 1'b1;
    brk_ev <= 1'b1;
    @(posedge pclk);
    cc_ev <= 1'b0;
    brk_ev <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({30'h0, irq_cc, irq_break}, 32'h3);
    rdchk(OFF_STATUS, 32'h83);
    apb(1'b1, OFF_STATUS, 32'h0);
    rdchk(OFF_STATUS, 32'h0);
  endtask
  task automatic t_burst();
    apb(1'b1, OFF_DMA_CTRL, 32'h0000010B);
    apb(1'b1, OFF_WINDOW, 32'h00000007);
    apb(1'b1, OFF_WINDOW, 32'h00000002);
    rdchk(OFF_RELOAD, 32'h7);
    rdchk(OFF_REPEAT, 32'h2);
    rdchk(OFF_WINDOW, 32'h7);
  endtask
  task automatic t_up_repeat();
    apb(1'b1, OFF_PRESCALE, 32'h1);
    apb(1'b1, OFF_RELOAD, 32'h3);
    apb(1'b1, OFF_REPEAT, 32'h1);
    apb(1'b1, OFF_EVGEN, 32'h1);
    apb(1'b1, OFF_CTRL1, 32'h1);
    wait_trgo(t1);
    wait_trgo(t1);
    wait_trgo(t2);
    chk(t2 - t1, 32'd16);
    apb(1'b1, OFF_CTRL1, 32'h3);
    wait_trgo(t1);
    chk(t1, 32'hFFFFFFFF);
    apb(1'b1, OFF_CTRL1, 32'h0);
  endtask
  task automatic t_itr_clock();
    apb(1'b1, OFF_PRESCALE, 32'h0);
    apb(1'b1, OFF_RELOAD, 32'hFFFF);
    apb(1'b1, OFF_SLAVE, 32'h7);
    apb(1'b1, OFF_EVGEN, 32'h1);
    apb(1'b1, OFF_CTRL1, 32'h1);
    u_master_timer_model.emit(5);
    repeat (4) @(posedge pclk);
    rdchk(OFF_COUNTER, 32'h5);
    apb(1'b1, OFF_DMA_CTRL, 32'h00000009);
    rdchk(OFF_WINDOW, 32'h5);
  endtask
  task automatic t_modes();
    apb(1'b1, OFF_RELOAD, 32'h3);
    apb(1'b1, OFF_EVGEN, 32'h1);
    apb(1'b1, OFF_CTRL1, 32'h11);
    u_master_timer_model.emit(2);
    rdchk(OFF_COUNTER, 32'h2);
    apb(1'b1, OFF_CTRL1, 32'h21);
    apb(1'b1, OFF_EVGEN, 32'h1);
    u_master_timer_model.emit(5);
    rdchk(OFF_COUNTER, 32'h1);
    apb(1'b1, OFF_SLAVE, 32'h1);
    apb(1'b1, OFF_CTRL1, 32'h1);
    apb(1'b1, OFF_EVGEN, 32'h1);
    pin_pulses(3, 5'h10);
    rdchk(OFF_COUNTER, 32'h3);
    apb(1'b1, OFF_SLAVE, 32'h57);
    apb(1'b1, OFF_EVGEN, 32'h1);
    pin_pulses(2, 5'h01);
    rdchk(OFF_COUNTER, 32'h2);
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    t_requests();
    t_burst();
    t_up_repeat();
    t_itr_clock();
    t_modes();
    results();
  end
endmodule
`default_nettype wire
